// [include/ide_pkg.sv]
// instruction decode and execute package: widths, field positions, opcodes, helpers
// assumes a 14-bit program word, a 13-bit program counter and a 128-entry file bank
// What this block does
// - fixed 14-bit word: opcode plus operand fields
// - three classes: byte, bit, literal/control
// - d=0 result to W, d=1 to file
// - file address spans 0x00 to 0x7f
// - bit select acts on one bit only
// - literal is 8 bits, jumps use 11
// - instruction cycle is four clock periods
// - skip or jump costs a second NOP cycle
// - file operand always read before store
// - don't-care encoding bits are ignored
// - d bit sits above 7-bit address
// - 3-bit bit number above 7-bit address
// - only call and goto use 11 bits
// - port read-modify-write samples pin levels
package ide_pkg;
    // widths
    localparam int unsigned INSTR_W   = 14;
    localparam int unsigned FETCH_AW  = 13;
    localparam int unsigned FILE_AW   = 7;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned K11_W     = 11;
    localparam int unsigned SP_W      = 3;
    localparam int unsigned STACK_DEP = 8;
    // field positions inside the word
    localparam int unsigned D_POS     = 7;
    localparam int unsigned B_LSB     = 7;
    localparam int unsigned CLS_LSB   = 12;
    // reset values and fixed words
    localparam logic [13:0] NOP_WORD  = 14'h0000;
    localparam logic [12:0] FETCH_RST = 13'h0000;
    localparam logic [7:0]  W_RST     = 8'h00;
    localparam logic [6:0]  FILE_MIN  = 7'h00;
    localparam logic [6:0]  FILE_MAX  = 7'h7f;
    // file addresses whose reads return pin levels
    localparam logic [6:0]  PORT_FIRST = 7'h05;
    localparam logic [6:0]  PORT_LAST  = 7'h09;

    typedef enum logic [1:0] {
        CLS_BYTE = 2'b00,
        CLS_BIT  = 2'b01,
        CLS_LIT  = 2'b10
    } ide_cls_t;

    typedef enum logic [5:0] {
        OP_NOP, OP_MOVWF, OP_CLRF, OP_CLRW, OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF,
        OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ, OP_RRF, OP_RLF,
        OP_SWAPF, OP_INCFSZ, OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS, OP_CALL, OP_GOTO,
        OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW, OP_XORLW, OP_SUBLW, OP_ADDLW,
        OP_RETURN, OP_RETFIE, OP_SLEEP, OP_CLRWDT
    } ide_op_t;

    // quarter phases of one instruction cycle, gray along the path
    typedef enum logic [1:0] {
        IDE_Q1 = 2'b00,
        IDE_Q2 = 2'b01,
        IDE_Q3 = 2'b11,
        IDE_Q4 = 2'b10
    } ide_phase_t;

    // returns {carry, digit carry, sum}
    function automatic logic [9:0] ide_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {full[8], lo[4], full[7:0]};
    endfunction

    function automatic logic ide_is_port(input logic [6:0] a);
        return (a >= PORT_FIRST) && (a <= PORT_LAST);
    endfunction
endpackage

// [include/ide_dec_if.sv]
// decoded instruction fields passed from decoder to execute core
// assumes ide_pkg compiled first
`timescale 1ns/1ps
interface ide_dec_if;
    logic [13:0]        instr;
    ide_pkg::ide_cls_t  cls;
    ide_pkg::ide_op_t   op;
    logic [6:0]         f_addr;
    logic               dest_f;
    logic [2:0]         bit_sel;
    logic [7:0]         k8;
    logic [10:0]        k11;
    logic               uses_file;

    modport decoder (input instr, output cls, op, f_addr, dest_f, bit_sel, k8, k11, uses_file);
    modport core    (output instr, input cls, op, f_addr, dest_f, bit_sel, k8, k11, uses_file);
endinterface

// [logic/ide_decode.sv]
// combinational decoder: 14-bit word to class, operation and operand fields
// assumes the word is held stable by the core for a whole instruction cycle
`timescale 1ns/1ps
module ide_decode (
    ide_dec_if.decoder dec
);
    logic [13:0] w;

    assign w = dec.instr;

    // operand fields at fixed positions, used by whichever class owns them
    assign dec.f_addr  = w[6:0];
    assign dec.dest_f  = w[ide_pkg::D_POS];
    assign dec.bit_sel = w[ide_pkg::B_LSB +: 3];
    assign dec.k8      = w[7:0];
    assign dec.k11     = w[10:0];

    // class from the two top bits; 10 and 11 are both literal/control
    always_comb begin
        case (w[ide_pkg::CLS_LSB +: 2])
            2'b00:   dec.cls = ide_pkg::CLS_BYTE;
            2'b01:   dec.cls = ide_pkg::CLS_BIT;
            default: dec.cls = ide_pkg::CLS_LIT;
        endcase
    end

    // opcode decode; don't-care bits are never looked at
    always_comb begin
        dec.op = ide_pkg::OP_NOP;
        case (w[13:12])
            2'b00: begin
                case (w[11:8])
                    4'h0: begin
                        if (w[7]) begin
                            dec.op = ide_pkg::OP_MOVWF;
                        end else if (w[6:0] == 7'h08) begin
                            dec.op = ide_pkg::OP_RETURN;
                        end else if (w[6:0] == 7'h09) begin
                            dec.op = ide_pkg::OP_RETFIE;
                        end else if (w[6:0] == 7'h63) begin
                            dec.op = ide_pkg::OP_SLEEP;
                        end else if (w[6:0] == 7'h64) begin
                            dec.op = ide_pkg::OP_CLRWDT;
                        end
                    end
                    4'h1: dec.op = w[7] ? ide_pkg::OP_CLRF : ide_pkg::OP_CLRW;
                    4'h2: dec.op = ide_pkg::OP_SUBWF;
                    4'h3: dec.op = ide_pkg::OP_DECF;
                    4'h4: dec.op = ide_pkg::OP_IORWF;
                    4'h5: dec.op = ide_pkg::OP_ANDWF;
                    4'h6: dec.op = ide_pkg::OP_XORWF;
                    4'h7: dec.op = ide_pkg::OP_ADDWF;
                    4'h8: dec.op = ide_pkg::OP_MOVF;
                    4'h9: dec.op = ide_pkg::OP_COMF;
                    4'ha: dec.op = ide_pkg::OP_INCF;
                    4'hb: dec.op = ide_pkg::OP_DECFSZ;
                    4'hc: dec.op = ide_pkg::OP_RRF;
                    4'hd: dec.op = ide_pkg::OP_RLF;
                    4'he: dec.op = ide_pkg::OP_SWAPF;
                    default: dec.op = ide_pkg::OP_INCFSZ;
                endcase
            end
            2'b01: begin
                case (w[11:10])
                    2'b00:   dec.op = ide_pkg::OP_BCF;
                    2'b01:   dec.op = ide_pkg::OP_BSF;
                    2'b10:   dec.op = ide_pkg::OP_BTFSC;
                    default: dec.op = ide_pkg::OP_BTFSS;
                endcase
            end
            2'b10: dec.op = w[11] ? ide_pkg::OP_GOTO : ide_pkg::OP_CALL;
            default: begin
                // low operation bits ignored where the encoding marks them free
                if (w[11:10] == 2'b00) begin
                    dec.op = ide_pkg::OP_MOVLW;
                end else if (w[11:10] == 2'b01) begin
                    dec.op = ide_pkg::OP_RETLW;
                end else if (w[11:8] == 4'h8) begin
                    dec.op = ide_pkg::OP_IORLW;
                end else if (w[11:8] == 4'h9) begin
                    dec.op = ide_pkg::OP_ANDLW;
                end else if (w[11:8] == 4'ha) begin
                    dec.op = ide_pkg::OP_XORLW;
                end else if (w[11:9] == 3'b110) begin
                    dec.op = ide_pkg::OP_SUBLW;
                end else if (w[11:9] == 3'b111) begin
                    dec.op = ide_pkg::OP_ADDLW;
                end
            end
        endcase
    end

    // every byte or bit operation on a file, writers included, reads it first
    always_comb begin
        case (dec.op)
            ide_pkg::OP_NOP, ide_pkg::OP_CLRW, ide_pkg::OP_RETURN, ide_pkg::OP_RETFIE,
            ide_pkg::OP_SLEEP, ide_pkg::OP_CLRWDT: dec.uses_file = 1'b0;
            default: dec.uses_file = (dec.cls != ide_pkg::CLS_LIT);
        endcase
    end
endmodule

// [logic/ide_core.sv]
// instruction decode and execute core: quarter-phase sequencer, fetch, ALU, stack
// assumes synchronous-read program memory and a file space answering within a quarter
`timescale 1ns/1ps
module ide_core (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // program memory
    output logic [12:0]      pmem_addr_o,
    input  wire logic [13:0] pmem_data_i,
    // file register space
    output logic [6:0]       file_addr_o,
    output logic             file_rd_o,
    output logic             file_wr_o,
    output logic [7:0]       file_wdata_o,
    input  wire logic [7:0]  file_rdata_i,
    input  wire logic [7:0]  port_pin_i,
    // core state
    output logic [7:0]       w_o,
    output logic [2:0]       status_o,
    output logic             instr_strobe_o,
    output logic             sleep_o,
    output logic             wdt_clr_o
);
    ide_dec_if dec ();

    ide_pkg::ide_phase_t q_r;
    logic [13:0]         instr_r;
    logic [12:0]         program_counter_r;
    logic [7:0]          rd_r;
    logic [7:0]          pin_meta_r;
    logic [7:0]          pin_sync_r;
    logic                branch_r;
    logic [12:0]         target_r;
    logic [12:0]         stack_mem [ide_pkg::STACK_DEP];
    logic [2:0]          sp_r;
    logic                c_r;
    logic                dc_r;
    logic                z_r;
    // execute results
    logic [9:0]          sum;
    logic [7:0]          res;
    logic                dst_op;
    logic                wr_f;
    logic                wr_w;
    logic                upd_z;
    logic                upd_c;
    logic                upd_dc;
    logic                c_nxt;
    logic                jump;
    logic                skip;
    logic                push;
    logic                pop;
    logic [12:0]         tgt;
    logic [7:0]          bit_mask;

    ide_decode u_decode (
        .dec (dec)
    );

    assign dec.instr   = instr_r;
    assign pmem_addr_o = program_counter_r;
    assign status_o    = {z_r, dc_r, c_r};
    assign bit_mask    = 8'h01 << dec.bit_sel;

    // quarter sequencer: four clocks make one instruction cycle
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            q_r            <= ide_pkg::IDE_Q1;
            instr_strobe_o <= 1'b0;
        end else begin
            case (q_r)
                ide_pkg::IDE_Q1: q_r <= ide_pkg::IDE_Q2;
                ide_pkg::IDE_Q2: q_r <= ide_pkg::IDE_Q3;
                ide_pkg::IDE_Q3: q_r <= ide_pkg::IDE_Q4;
                default:         q_r <= ide_pkg::IDE_Q1;
            endcase
            instr_strobe_o <= (q_r == ide_pkg::IDE_Q4);
        end
    end

    // pin levels come from outside, so two flops before use
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end else begin
            pin_meta_r <= port_pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // fetch: the prefetched word is dropped after a skip or jump
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            instr_r           <= ide_pkg::NOP_WORD;
            program_counter_r <= ide_pkg::FETCH_RST;
        end else if (q_r == ide_pkg::IDE_Q4) begin
            instr_r           <= branch_r ? ide_pkg::NOP_WORD : pmem_data_i;
            program_counter_r <= branch_r ? target_r : program_counter_r + 13'h0001;
        end
    end

    // file port: address in Q2, sample at end of Q2, write strobe in Q4
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            file_addr_o  <= ide_pkg::FILE_MIN;
            file_rd_o    <= 1'b0;
            file_wr_o    <= 1'b0;
            file_wdata_o <= 8'h00;
            rd_r         <= 8'h00;
        end else begin
            case (q_r)
                ide_pkg::IDE_Q1: begin
                    file_addr_o <= dec.f_addr;
                    file_rd_o   <= dec.uses_file;
                end
                ide_pkg::IDE_Q2: begin
                    file_rd_o <= 1'b0;
                    // ports return what the pins show, not the output latch
                    rd_r <= ide_pkg::ide_is_port(file_addr_o) ? pin_sync_r
                                                              : file_rdata_i;
                end
                ide_pkg::IDE_Q3: begin
                    file_wr_o    <= wr_f;
                    file_wdata_o <= res;
                end
                default: file_wr_o <= 1'b0;
            endcase
        end
    end

    // execute: one ALU shared by byte, bit and literal classes
    always_comb begin
        sum    = 10'h000;
        res    = 8'h00;
        dst_op = 1'b0;
        wr_f   = 1'b0;
        wr_w   = 1'b0;
        upd_z  = 1'b0;
        upd_c  = 1'b0;
        upd_dc = 1'b0;
        c_nxt  = c_r;
        jump   = 1'b0;
        skip   = 1'b0;
        push   = 1'b0;
        pop    = 1'b0;
        tgt    = program_counter_r + 13'h0001;
        case (dec.op)
            ide_pkg::OP_MOVWF: begin res = w_o; wr_f = 1'b1; end
            ide_pkg::OP_CLRF:  begin wr_f = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_CLRW:  begin wr_w = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_SUBWF: begin
                sum = ide_pkg::ide_add(rd_r, ~w_o, 1'b1);
                res = sum[7:0]; dst_op = 1'b1; upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
            end
            ide_pkg::OP_ADDWF: begin
                sum = ide_pkg::ide_add(rd_r, w_o, 1'b0);
                res = sum[7:0]; dst_op = 1'b1; upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
            end
            ide_pkg::OP_DECF:   begin res = rd_r - 8'h01; dst_op = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_INCF:   begin res = rd_r + 8'h01; dst_op = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_IORWF:  begin res = rd_r | w_o; dst_op = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_ANDWF:  begin res = rd_r & w_o; dst_op = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_XORWF:  begin res = rd_r ^ w_o; dst_op = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_MOVF:   begin res = rd_r; dst_op = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_COMF:   begin res = ~rd_r; dst_op = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_SWAPF:  begin res = {rd_r[3:0], rd_r[7:4]}; dst_op = 1'b1; end
            ide_pkg::OP_DECFSZ: begin res = rd_r - 8'h01; dst_op = 1'b1; skip = (res == 8'h00); end
            ide_pkg::OP_INCFSZ: begin res = rd_r + 8'h01; dst_op = 1'b1; skip = (res == 8'h00); end
            ide_pkg::OP_RRF: begin res = {c_r, rd_r[7:1]}; c_nxt = rd_r[0]; dst_op = 1'b1; end
            ide_pkg::OP_RLF: begin res = {rd_r[6:0], c_r}; c_nxt = rd_r[7]; dst_op = 1'b1; end
            // single-bit ops touch only the selected bit
            ide_pkg::OP_BCF:   begin res = rd_r & ~bit_mask; wr_f = 1'b1; end
            ide_pkg::OP_BSF:   begin res = rd_r | bit_mask; wr_f = 1'b1; end
            ide_pkg::OP_BTFSC: skip = ((rd_r & bit_mask) == 8'h00);
            ide_pkg::OP_BTFSS: skip = ((rd_r & bit_mask) != 8'h00);
            // upper two target bits stay from the current page
            ide_pkg::OP_CALL: begin
                jump = 1'b1; push = 1'b1;
                tgt = {program_counter_r[12:11], dec.k11};
            end
            ide_pkg::OP_GOTO: begin
                jump = 1'b1;
                tgt = {program_counter_r[12:11], dec.k11};
            end
            ide_pkg::OP_RETURN, ide_pkg::OP_RETFIE: begin
                jump = 1'b1; pop = 1'b1; tgt = stack_mem[sp_r - 3'd1];
            end
            ide_pkg::OP_RETLW: begin
                jump = 1'b1; pop = 1'b1; tgt = stack_mem[sp_r - 3'd1];
                res = dec.k8; wr_w = 1'b1;
            end
            ide_pkg::OP_MOVLW: begin res = dec.k8; wr_w = 1'b1; end
            ide_pkg::OP_IORLW: begin res = w_o | dec.k8; wr_w = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_ANDLW: begin res = w_o & dec.k8; wr_w = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_XORLW: begin res = w_o ^ dec.k8; wr_w = 1'b1; upd_z = 1'b1; end
            ide_pkg::OP_SUBLW: begin
                sum = ide_pkg::ide_add(dec.k8, ~w_o, 1'b1);
                res = sum[7:0]; wr_w = 1'b1; upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
            end
            ide_pkg::OP_ADDLW: begin
                sum = ide_pkg::ide_add(dec.k8, w_o, 1'b0);
                res = sum[7:0]; wr_w = 1'b1; upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
            end
            default: res = 8'h00;
        endcase
        // destination select on byte ops
        if (dst_op) begin
            wr_f = dec.dest_f;
            wr_w = !dec.dest_f;
        end
        if (upd_c) begin
            c_nxt = sum[9];
        end
    end

    // accumulator, flags and branch decision land at the end of Q3
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            w_o      <= ide_pkg::W_RST;
            c_r      <= 1'b0;
            dc_r     <= 1'b0;
            z_r      <= 1'b0;
            branch_r <= 1'b0;
            target_r <= ide_pkg::FETCH_RST;
        end else if (q_r == ide_pkg::IDE_Q3) begin
            if (wr_w) begin
                w_o <= res;
            end
            c_r      <= c_nxt;
            dc_r     <= upd_dc ? sum[8] : dc_r;
            z_r      <= upd_z ? (res == 8'h00) : z_r;
            branch_r <= jump | skip;
            target_r <= tgt;
        end else if (q_r == ide_pkg::IDE_Q4) begin
            branch_r <= 1'b0;
        end
    end

    // return stack; overflow wraps silently, as the hardware has no trap
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sp_r <= 3'd0;
        end else if (q_r == ide_pkg::IDE_Q3) begin
            if (push) begin
                stack_mem[sp_r] <= program_counter_r;
                sp_r            <= sp_r + 3'd1;
            end else if (pop) begin
                sp_r <= sp_r - 3'd1;
            end
        end
    end

    // one-cycle pulses for the sleep and watchdog logic outside
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sleep_o   <= 1'b0;
            wdt_clr_o <= 1'b0;
        end else begin
            sleep_o   <= (q_r == ide_pkg::IDE_Q3) && (dec.op == ide_pkg::OP_SLEEP);
            wdt_clr_o <= (q_r == ide_pkg::IDE_Q3) && (dec.op == ide_pkg::OP_CLRWDT);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_cycle_four: assert property (instr_strobe_o |=>
        !instr_strobe_o [*3] ##1 instr_strobe_o)
        else $error("instruction strobe not every fourth clock");
    chk_read_before_wr: assert property (file_wr_o |-> $past(file_rd_o, 2))
        else $error("file written without a read first");
    chk_dest_select: assert property ((q_r == ide_pkg::IDE_Q3 && dst_op) |=>
        (file_wr_o == $past(dec.dest_f)) && (!$past(dec.dest_f) -> w_o == file_wdata_o))
        else $error("destination select not honoured");
    chk_file_addr: assert property ((q_r == ide_pkg::IDE_Q2 && file_rd_o) |->
        file_addr_o == instr_r[6:0] && file_addr_o <= ide_pkg::FILE_MAX)
        else $error("file address not taken from low seven bits");
    chk_bit_only: assert property ((q_r == ide_pkg::IDE_Q3 &&
        dec.cls == ide_pkg::CLS_BIT && wr_f)
        |=> ((file_wdata_o ^ rd_r) & ~(8'h01 << instr_r[9:7])) == 8'h00)
        else $error("bit operation changed another bit");
    chk_two_cycle: assert property ((q_r == ide_pkg::IDE_Q4 && branch_r) |=>
        instr_r == ide_pkg::NOP_WORD && program_counter_r == $past(target_r))
        else $error("flush or refetch missing after branch");
    chk_goto_target: assert property ((q_r == ide_pkg::IDE_Q3 &&
        dec.op == ide_pkg::OP_GOTO) |=> branch_r && target_r[10:0] == instr_r[10:0])
        else $error("jump target not the 11-bit field");
    chk_lit_load: assert property ((q_r == ide_pkg::IDE_Q3 &&
        dec.op == ide_pkg::OP_MOVLW) |=> w_o == instr_r[7:0])
        else $error("literal not loaded into accumulator");
    chk_port_pins: assert property ((q_r == ide_pkg::IDE_Q2 &&
        ide_pkg::ide_is_port(file_addr_o)) |=> rd_r == $past(pin_sync_r))
        else $error("port read did not use pin levels");
    chk_class_map: assert property ((instr_r[13:12] == 2'b01) |->
        dec.cls == ide_pkg::CLS_BIT)
        else $error("bit class mis-sorted");
    chk_dont_care: assert property ((instr_r[13:8] == 6'h01 && !instr_r[7]) |->
        dec.op == ide_pkg::OP_CLRW && !dec.uses_file)
        else $error("don't-care bits changed decode");
    chk_one_cycle: assert property ((q_r == ide_pkg::IDE_Q3 && !jump && !skip) |=>
        !branch_r)
        else $error("plain instruction took two cycles");

    cov_goto: cover property (q_r == ide_pkg::IDE_Q3 && dec.op == ide_pkg::OP_GOTO);
    cov_skip: cover property (q_r == ide_pkg::IDE_Q3 && skip);
    cov_return: cover property (q_r == ide_pkg::IDE_Q3 && pop);
    cov_port_rmw: cover property (file_wr_o && ide_pkg::ide_is_port(file_addr_o));
endmodule

// [testbench/ide_mem_model.sv]
// program memory and file space partner for the decode core
// assumes the bench fills rom and regs before reset is released
`timescale 1ns/1ps
module ide_mem_model (
    // program side
    input  wire logic [12:0] pmem_addr_i,
    output logic [13:0]      pmem_data_o,
    // file side
    input  wire logic        clk_i,
    input  wire logic [6:0]  file_addr_i,
    input  wire logic        file_rd_i,
    input  wire logic        file_wr_i,
    input  wire logic [7:0]  file_wdata_i,
    output logic [7:0]       file_rdata_o
);
    logic [13:0] rom  [0:127];
    logic [7:0]  regs [0:127];
    // only 128 words modelled, upper address bits ignored
    assign pmem_data_o = rom[pmem_addr_i[6:0]];
    // wrong data outside the strobe, so a late sample shows
    assign file_rdata_o = file_rd_i ? regs[file_addr_i] : ~regs[file_addr_i];
    // write lands on the strobe edge
    always @(posedge clk_i) if (file_wr_i) regs[file_addr_i] <= file_wdata_i;
endmodule

// [testbench/instruction_decode_execute_test.sv]
// self-checking bench: straight-line program, then skip, jump and port cases
// assumes ide_pkg, the decoder interface and the core are compiled first
`timescale 1ns/1ps
module instruction_decode_execute_test;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic [7:0]  port_pin_i = 8'ha5;
    logic [12:0] pmem_addr_o;
    logic [13:0] pmem_data_i;
    logic [6:0]  file_addr_o;
    logic        file_rd_o, file_wr_o, instr_strobe_o, sleep_o, wdt_clr_o;
    logic [7:0]  file_wdata_o, file_rdata_i, w_o;
    logic [2:0]  status_o;
    int          errors = 0;
    int          compares = 0;
    int          n;
    int          sleeps = 0;
    int          wdt_clears = 0;
    // {word, accumulator after it}
    logic [21:0] rows [0:10] = '{{14'h303c, 8'h3c}, {14'h3e05, 8'h41}, {14'h00a0, 8'h41},
        {14'h0a20, 8'h42}, {14'h0aa0, 8'h42}, {14'h17a0, 8'h42}, {14'h0820, 8'hc2},
        {14'h390f, 8'h02}, {14'h3355, 8'h55}, {14'h0806, 8'ha5}, {14'h01a1, 8'ha5}};
    always #12.5 core_clk_i = ~core_clk_i;
    // the pulses last one clock only, so count them on every edge
    always @(posedge core_clk_i) begin
        if (sleep_o === 1'b1) sleeps++;
        if (wdt_clr_o === 1'b1) wdt_clears++;
    end
    ide_core DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .pmem_addr_o(pmem_addr_o),
        .pmem_data_i(pmem_data_i), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
        .file_wr_o(file_wr_o), .file_wdata_o(file_wdata_o), .file_rdata_i(file_rdata_i),
        .port_pin_i(port_pin_i), .w_o(w_o), .status_o(status_o),
        .instr_strobe_o(instr_strobe_o), .sleep_o(sleep_o), .wdt_clr_o(wdt_clr_o));
    ide_mem_model mem (.pmem_addr_i(pmem_addr_o), .pmem_data_o(pmem_data_i),
        .clk_i(core_clk_i), .file_addr_i(file_addr_o), .file_rd_i(file_rd_o),
        .file_wr_i(file_wr_o), .file_wdata_i(file_wdata_o), .file_rdata_o(file_rdata_i));
    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // bounded wait for the cycle that fetches address a; n counts clocks
    task automatic wait_addr(input logic [12:0] a);
        n = 0;
        while (!(instr_strobe_o === 1'b1 && pmem_addr_o === a)) begin
            @(posedge core_clk_i);
            #1;
            n++;
            if (n > 60) begin
                errors++;
                final_report();
            end
        end
    endtask
    initial begin
        for (int i = 0; i < 128; i++) mem.rom[i] = 14'h0000;
        for (int i = 0; i < 128; i++) mem.regs[i] = 8'hff;
        for (int i = 0; i < 11; i++) mem.rom[i] = rows[i][21:8];
        mem.rom[11] = 14'h1fa0;  // bit test, skips
        mem.rom[12] = 14'h3099;  // must be skipped
        mem.rom[13] = 14'h2840;  // jump to 0x40
        mem.rom[14] = 14'h3099;  // prefetched, must be dropped
        mem.rom[64] = 14'h3077;
        mem.rom[65] = 14'h0806;  // port read, pins differ from latch
        mem.rom[66] = 14'h0a86;  // port increment back into the latch
        mem.rom[67] = 14'h0063;  // sleep pulse
        mem.rom[68] = 14'h0064;  // watchdog clear pulse
        mem.regs[6] = 8'h3c;     // latch differs from pins
        repeat (5) @(posedge core_clk_i);
        #1;
        check(16'(pmem_addr_o), 16'h0000, "reset address");
        check(16'(w_o), 16'h0000, "reset accumulator");
        $display("test reset done");
        sys_rst_i = 1'b0;
        // result of word i is in place when word i+1 executes
        for (int i = 0; i < 11; i++) begin
            wait_addr(13'(i + 2));
            check(16'(w_o), 16'(rows[i][7:0]), "row");
        end
        check(16'(mem.regs[32]), 16'h00c2, "file bits");
        check(16'(status_o), 16'h0006, "flags");
        check(16'(mem.regs[33]), 16'h0000, "clear file");
        $display("test rows done");
        n = 0;
        wait_addr(13'd14);
        check(16'(n), 16'd8, "skip costs two cycles");
        check(16'(w_o), 16'h00a5, "skipped word ran");
        // new pin levels well ahead of the next port read, past the two sync flops
        port_pin_i = 8'h5a;
        wait_addr(13'h042);
        check(16'(n), 16'd12, "jump cycles");
        check(16'(w_o), 16'h0077, "jump target");
        $display("test branch done");
        // port read and port increment both see the pins, not the latch
        wait_addr(13'h044);
        check(16'(w_o), 16'h005a, "port read");
        check(16'(mem.regs[6]), 16'h005b, "port rmw");
        wait_addr(13'h046);
        check(16'(sleeps), 16'd1, "sleep pulse");
        check(16'(wdt_clears), 16'd1, "watchdog pulse");
        $display("test port done");
        // reset in mid-run: back to address zero, clean accumulator and flags
        sys_rst_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        check(16'(pmem_addr_o), 16'h0000, "rerun address");
        check(16'(w_o), 16'h0000, "rerun accumulator");
        check(16'(status_o), 16'h0000, "rerun flags");
        sys_rst_i = 1'b0;
        wait_addr(13'd2);
        check(16'(n), 16'd8, "cycles after reset");
        check(16'(w_o), 16'h003c, "rerun first word");
        $display("test reset again done");
        final_report();
    end
endmodule
